// ==== core/usb_host_irq_status_enable.sv ====
// interrupt source flags, per-source enables with master enable,
// and the combined interrupt request of a usb host controller.
// assumes event inputs come from logic on core_clk and that the
// apb master follows the usual setup / access protocol.
//
// Notes on behaviour
// - ownership request write sets ownership flag
// - unmasked ownership flag raises management interrupt
// - zero written clears ownership flag
// - root hub or port change sets flag
// - zero written clears hub, frame-start flags
// - frame counter msb toggle sets overflow flag
// - system error sets unrecoverable error flag
// - resume signalling sets resume flag
// - every frame start sets frame-start flag
// - done head writeback sets done flag
// - schedule overrun sets overrun flag
// - enable register at 0x10, bit per source
// - bit 31 master enable gates sources; here it gates irq_req only, system_mgmt_irq ignores it
// - enable write one sets, zero ignored
// - disable register write one clears enable
// - enable bit maps to same flag bit
// - request needs flag, enable, master together
// - flags bit 31 reads zero always
// - disable register at 0x14 reads enables
`default_nettype none

module usb_host_irq_status_enable (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // event sources from the host controller core
  input  wire logic [31:0] root_hub_state,
  input  wire logic [31:0] root_port_state1,
  input  wire logic [31:0] root_port_state2,
  input  wire logic        frame_counter_msb,
  input  wire logic        unrecoverable_error,
  input  wire logic        resume_detect,
  input  wire logic        start_of_frame,
  input  wire logic        writeback_done_head,
  input  wire logic        schedule_overrun,
  // interrupt requests
  output logic             irq_req,
  output logic             system_mgmt_irq
);

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic        access;
  logic        commit;
  logic        hit_cmd;
  logic        hit_flags;
  logic        hit_mask;
  logic        hit_mask_clr;
  logic        mapped;
  logic        wr_cmd;
  logic        wr_flags;
  logic        wr_mask;
  logic        wr_mask_clr;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] read_d;

  // bus response sequencer: idle until an access, then one answer
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_RESP = 1'b1
  } bus_state_t;

  bus_state_t  bus_q;
  bus_state_t  bus_d;
  logic        answer_d;

  assign access       = psel & penable;
  // one wait state keeps every bus output on a flip-flop
  assign commit       = access & pready_q;
  assign hit_cmd      = paddr == irq_status_pkg::CMD_OFFSET;
  assign hit_flags    = paddr == irq_status_pkg::FLAGS_OFFSET;
  assign hit_mask     = paddr == irq_status_pkg::MASK_OFFSET;
  assign hit_mask_clr = paddr == irq_status_pkg::MASK_CLR_OFFSET;
  assign mapped       = hit_cmd | hit_flags | hit_mask | hit_mask_clr;
  assign wr_cmd       = commit & pwrite & hit_cmd;
  assign wr_flags     = commit & pwrite & hit_flags;
  assign wr_mask      = commit & pwrite & hit_mask;
  assign wr_mask_clr  = commit & pwrite & hit_mask_clr;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0] flags_q;
  logic [31:0] mask_q;
  logic [31:0] event_set;
  logic [31:0] hub_prev_q;
  logic [31:0] port1_prev_q;
  logic [31:0] port2_prev_q;
  logic        frame_msb_prev_q;
  logic        primed_q;
  logic        hub_diff;
  logic        port1_diff;
  logic        port2_diff;
  logic        hub_change;
  logic        frame_toggle;
  logic        master_on;
  logic [31:0] pending;
  logic        own_request;
  logic        irq_req_q;
  logic        smi_q;
  logic        irq_d;
  logic        smi_d;

  // per-bit next values, each bit driven once by the slice loop
  wire logic [31:0] flags_d;
  wire logic [31:0] flag_clr;
  wire logic [31:0] mask_d;
  wire logic [31:0] mask_set;
  wire logic [31:0] mask_clr;

  // ----------------------------------------------------------------
  // change detection
  // ----------------------------------------------------------------
  // primed_q skips the first compare so reset values raise nothing
  always_ff @(posedge core_clk) begin
    if (reset) begin
      primed_q <= 1'b0;
    end else begin
      primed_q <= 1'b1;
    end
  end

  // one history register per watched source
  always_ff @(posedge core_clk) begin
    if (reset) begin
      hub_prev_q <= irq_status_pkg::READ_ZERO;
    end else begin
      hub_prev_q <= root_hub_state;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      port1_prev_q <= irq_status_pkg::READ_ZERO;
    end else begin
      port1_prev_q <= root_port_state1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      port2_prev_q <= irq_status_pkg::READ_ZERO;
    end else begin
      port2_prev_q <= root_port_state2;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      frame_msb_prev_q <= 1'b0;
    end else begin
      frame_msb_prev_q <= frame_counter_msb;
    end
  end

  // whole words compared: a change of any one bit is enough
  assign hub_diff     = hub_prev_q != root_hub_state;
  assign port1_diff   = port1_prev_q != root_port_state1;
  assign port2_diff   = port2_prev_q != root_port_state2;
  assign hub_change   = primed_q &
                        (hub_diff | port1_diff | port2_diff);
  assign frame_toggle = primed_q &
                        (frame_msb_prev_q != frame_counter_msb);

  // request bit in the command register is write-only, self-clearing
  assign own_request =
    wr_cmd & pwdata[irq_status_pkg::OWN_REQ_BIT];

  // ----------------------------------------------------------------
  // event vector, one set term per flag position
  // ----------------------------------------------------------------
  always_comb begin
    event_set = irq_status_pkg::READ_ZERO;
    event_set[irq_status_pkg::OWNERSHIP_BIT] = own_request;
    event_set[irq_status_pkg::ROOT_HUB_BIT]  = hub_change;
    event_set[irq_status_pkg::FRAME_OVF_BIT] = frame_toggle;
    event_set[irq_status_pkg::UNRECOV_BIT]   = unrecoverable_error;
    event_set[irq_status_pkg::RESUME_BIT]    = resume_detect;
    event_set[irq_status_pkg::SOF_BIT]       = start_of_frame;
    event_set[irq_status_pkg::DONE_HEAD_BIT] = writeback_done_head;
    event_set[irq_status_pkg::OVERRUN_BIT]   = schedule_overrun;
  end

  // ----------------------------------------------------------------
  // flags and enables, one slice per bit
  // ----------------------------------------------------------------
  for (genvar i = 0; i < irq_status_pkg::DATA_W; i++) begin : g_bit
    if (irq_status_pkg::SOURCE_BITS[i]) begin : g_src
      // a set arriving with the clearing write still wins
      assign flag_clr[i] = wr_flags & ~pwdata[i];
      assign flags_d[i]  = event_set[i] |
                           (flags_q[i] & ~flag_clr[i]);
      // write one sets; disable write one clears; zero is ignored
      assign mask_set[i] = wr_mask & pwdata[i];
      assign mask_clr[i] = wr_mask_clr & pwdata[i];
      assign mask_d[i]   = mask_set[i] |
                           (mask_q[i] & ~mask_clr[i]);
    end else if (i == irq_status_pkg::MASTER_BIT) begin : g_master
      // master enable lives in the mask register only
      assign flag_clr[i] = 1'b0;
      assign flags_d[i]  = 1'b0;
      assign mask_set[i] = wr_mask & pwdata[i];
      assign mask_clr[i] = wr_mask_clr & pwdata[i];
      assign mask_d[i]   = mask_set[i] |
                           (mask_q[i] & ~mask_clr[i]);
    end else begin : g_rsvd
      // reserved bits hold nothing and read back as zero
      assign flag_clr[i] = 1'b0;
      assign flags_d[i]  = 1'b0;
      assign mask_set[i] = 1'b0;
      assign mask_clr[i] = 1'b0;
      assign mask_d[i]   = 1'b0;
    end
  end

  // whole registers update together from the per-bit next values
  always_ff @(posedge core_clk) begin
    if (reset) begin
      flags_q <= irq_status_pkg::FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      mask_q <= irq_status_pkg::MASK_RESET;
    end else begin
      mask_q <= mask_d;
    end
  end

  // ----------------------------------------------------------------
  // interrupt requests
  // ----------------------------------------------------------------
  // same-position pairing of flag and enable, gated by master
  assign pending   = flags_q & mask_q & irq_status_pkg::SOURCE_BITS;
  assign master_on = mask_q[irq_status_pkg::MASTER_BIT];
  assign irq_d     = master_on & (|pending);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_req_q <= 1'b0;
    end else begin
      irq_req_q <= irq_d;
    end
  end

  // management request ignores the master enable: it must not wait
  assign smi_d = flags_q[irq_status_pkg::OWNERSHIP_BIT] &
                 mask_q[irq_status_pkg::OWNERSHIP_BIT];

  always_ff @(posedge core_clk) begin
    if (reset) begin
      smi_q <= 1'b0;
    end else begin
      smi_q <= smi_d;
    end
  end

  // ----------------------------------------------------------------
  // apb response
  // ----------------------------------------------------------------
  always_comb begin
    read_d = irq_status_pkg::READ_ZERO;
    case (paddr)
      irq_status_pkg::FLAGS_OFFSET: begin
        read_d = flags_q;
      end
      irq_status_pkg::MASK_OFFSET,
      irq_status_pkg::MASK_CLR_OFFSET: begin
        read_d = mask_q;
      end
      default: begin
        // command register is write-only; unmapped reads as zero
        read_d = irq_status_pkg::READ_ZERO;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // bus response sequencer
  // ----------------------------------------------------------------
  always_comb begin
    bus_d = bus_q;
    case (bus_q)
      BUS_IDLE: begin
        if (access) begin
          bus_d = BUS_RESP;
        end
      end
      BUS_RESP: begin
        // the answer lasts one cycle, whatever the master does
        bus_d = BUS_IDLE;
      end
      default: begin
        bus_d = BUS_IDLE;
      end
    endcase
  end

  // answer flops load from the next state so they stay registered
  assign answer_d = bus_d == BUS_RESP;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      bus_q <= BUS_IDLE;
    end else begin
      bus_q <= bus_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= answer_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      pslverr_q <= 1'b0;
    end else if (answer_d) begin
      pslverr_q <= ~mapped;
    end else begin
      pslverr_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      prdata_q <= irq_status_pkg::READ_ZERO;
    end else if (answer_d && !pwrite) begin
      prdata_q <= read_d;
    end else begin
      // data lines rest at zero outside a read answer
      prdata_q <= irq_status_pkg::READ_ZERO;
    end
  end

  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign irq_req         = irq_req_q;
  assign system_mgmt_irq = smi_q;

endmodule

`default_nettype wire

// ==== core/irq_status_pkg.sv ====
// holds register offsets, bit positions and reset values of the
// usb host interrupt status and enable block.
// assumes a 32-bit apb slave with word-aligned registers.
`default_nettype none

package irq_status_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_OFFSET       = 8'h08;
  localparam logic [7:0] FLAGS_OFFSET     = 8'h0c;
  localparam logic [7:0] MASK_OFFSET      = 8'h10;
  localparam logic [7:0] MASK_CLR_OFFSET  = 8'h14;
  localparam int         ADDR_W           = 8;
  localparam int         DATA_W           = 32;

  // ----------------------------------------------------------------
  // bit positions shared by flags and mask; MASTER_BIT is in the mask only
  // ----------------------------------------------------------------
  localparam int MASTER_BIT     = 31;
  localparam int OWNERSHIP_BIT  = 30;
  localparam int ROOT_HUB_BIT   = 6;
  localparam int FRAME_OVF_BIT  = 5;
  localparam int UNRECOV_BIT    = 4;
  localparam int RESUME_BIT     = 3;
  localparam int SOF_BIT        = 2;
  localparam int DONE_HEAD_BIT  = 1;
  localparam int OVERRUN_BIT    = 0;

  // ownership change request bit in the command register
  localparam int OWN_REQ_BIT    = 3;

  // frame counter bit whose toggle marks an overflow
  localparam int FRAME_MSB_BIT  = 15;

  // bits that hold a real source flag and its enable (30 and 6..0)
  localparam logic [31:0] SOURCE_BITS = 32'h4000_007f;
  localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET  = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO   = 32'h0000_0000;

endpackage

`default_nettype wire

// ==== testbench/irq_status_sva.sv ====
// concurrent checks on the interrupt status block's ports.
// assumes the one-wait-state apb slave described for the design.
`default_nettype none
module irq_status_sva (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        reset,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // events and requests
  input wire logic        frame_counter_msb,
  input wire logic        start_of_frame,
  input wire logic        irq_req,
  input wire logic        system_mgmt_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------------------------------
  // enable shadow, kept from apb writes alone
  // --------------------------------------------
  logic [31:0] en_q;
  logic        wr_c;
  assign wr_c = pready && pwrite;
  always_ff @(posedge core_clk) begin
    if (reset)
      en_q <= 32'h0000_0000;
    else if (wr_c && paddr == 8'h10)
      en_q <= en_q | (pwdata & 32'hc000_007f);
    else if (wr_c && paddr == 8'h14)
      en_q <= en_q & ~pwdata;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // --------------------------------------------
  // properties
  // --------------------------------------------
  AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("pready not one cycle after access");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_UNMAPPED: assert property (pready &&
    !(paddr inside {8'h08, 8'h0c, 8'h10, 8'h14}) |-> pslverr && !prdata)
    else $error("unmapped access not refused");
  AST_FLAGS_RSVD: assert property (
    pready && !pwrite && paddr == 8'h0c |-> !(prdata & 32'hbfff_ff80))
    else $error("reserved flag bits read nonzero");
  AST_EN_READ: assert property (
    pready && !pwrite && paddr == 8'h10 |-> prdata == en_q)
    else $error("enable read mismatch");
  AST_DIS_READ: assert property (
    pready && !pwrite && paddr == 8'h14 |-> prdata == en_q)
    else $error("disable read mismatch");
  AST_MASTER: assert property (!en_q[31] |=> !irq_req)
    else $error("irq without master enable");
  AST_SMI_MASK: assert property (system_mgmt_irq |-> $past(en_q[30]))
    else $error("management irq while masked");
  AST_OWN: assert property (wr_c && paddr == 8'h08 && pwdata[3]
    && en_q[30] |-> ##2 system_mgmt_irq)
    else $error("ownership request gave no irq");
  AST_SOF: assert property (start_of_frame && en_q[31] && en_q[2]
    && !wr_c |=> ##1 irq_req)
    else $error("frame start gave no irq");
  AST_FNO: assert property ($changed(frame_counter_msb) && en_q[31]
    && en_q[5] && !wr_c |=> ##1 irq_req)
    else $error("frame msb toggle gave no irq");
  AST_LEVEL: assert property (!wr_c ##1 irq_req |=> irq_req)
    else $error("irq dropped without a write");
  cover property (system_mgmt_irq);
  cover property (irq_req);
  cover property (pready && pslverr);
endmodule
bind usb_host_irq_status_enable irq_status_sva i_sva (
  .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .frame_counter_msb(frame_counter_msb), .start_of_frame(start_of_frame),
  .irq_req(irq_req), .system_mgmt_irq(system_mgmt_irq));
`default_nettype wire

// ==== testbench/usb_host_irq_status_enable_tb_top.sv ====
// self-checking bench for the interrupt status block.
// assumes the package, design and bound checker compile first.
`default_nettype none
`define CHK(n, g, e) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); \
  end \
end
module usb_host_irq_status_enable_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0;
  logic        reset    = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq_req;
  logic        system_mgmt_irq;
  logic [31:0] hub [3]  = '{32'h0, 32'h0, 32'h0};
  logic        fmsb     = 1'b0;
  logic [4:0]  ev       = 5'h00;
  logic [15:0] seed     = 16'h55c8;
  logic [32:0] exp_q [$];
  logic [32:0] e_now;
  int          fails       = 0;
  int          comparisons = 0;
  always #50 core_clk = ~core_clk;
  usb_host_irq_status_enable i_dut (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .root_hub_state(hub[0]), .root_port_state1(hub[1]),
    .root_port_state2(hub[2]), .frame_counter_msb(fmsb),
    .schedule_overrun(ev[0]), .writeback_done_head(ev[1]),
    .start_of_frame(ev[2]), .resume_detect(ev[3]),
    .unrecoverable_error(ev[4]), .irq_req(irq_req),
    .system_mgmt_irq(system_mgmt_irq));
  // --------------------------------------------
  // helpers
  // --------------------------------------------
  function automatic logic [31:0] lfsr();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return {seed, ~seed};
  endfunction
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // only the watchdog ends a wait for pready
    do begin
      @(posedge core_clk);
    end while (!pready);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask
  // sampled mid-cycle so the edge's updates have landed
  task automatic chk_irq(input logic i, input logic s);
    @(negedge core_clk);
    `CHK("irq_req", irq_req, i)
    `CHK("system_mgmt_irq", system_mgmt_irq, s)
    @(posedge core_clk);
  endtask
  always @(posedge core_clk) begin
    if (pready && !pwrite && exp_q.size() > 0) begin
      e_now = exp_q.pop_front();
      `CHK("read word", {pslverr, prdata}, e_now)
    end
  end
  task automatic conclude();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // --------------------------------------------
  // scenarios
  // --------------------------------------------
  initial begin
    logic [31:0] r;
    logic [31:0] m;
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rd(8'h10, 33'h0);
    rd(8'h0c, 33'h0);
    rd(8'h20, 33'h1_0000_0000);
    xfer(1'b1, 8'h10, 32'h4000_007f);
    ev <= 5'h04;
    @(posedge core_clk);
    ev <= 5'h00;
    chk_irq(1'b0, 1'b0);
    xfer(1'b1, 8'h10, 32'h8000_0000);
    chk_irq(1'b1, 1'b0);
    xfer(1'b1, 8'h10, 32'h0);
    rd(8'h10, {1'b0, 32'hc000_007f});
    xfer(1'b1, 8'h0c, 32'h0);
    xfer(1'b1, 8'h08, 32'h0000_0008);
    rd(8'h0c, {1'b0, 32'h4000_0000});
    chk_irq(1'b1, 1'b1);
    xfer(1'b1, 8'h0c, 32'h0);
    rd(8'h0c, 33'h0);
    for (int i = 0; i < 9; i++) begin
      if (i < 5)
        ev <= 5'h01 << i;
      else if (i == 5)
        fmsb <= ~fmsb;
      else
        hub[i-6] <= hub[i-6] ^ lfsr();
      @(posedge core_clk);
      ev <= 5'h00;
      r = (i < 5) ? 32'h1 << i : ((i == 5) ? 32'h20 : 32'h40);
      rd(8'h0c, {1'b0, r});
      chk_irq(1'b1, 1'b0);
      xfer(1'b1, 8'h0c, 32'h0);
      chk_irq(1'b0, 1'b0);
    end
    m = 32'hc000_007f;
    repeat (4) begin
      r = lfsr() & 32'hc000_007f;
      xfer(1'b1, 8'h14, r);
      m = m & ~r;
      rd(8'h14, {1'b0, m});
      r = lfsr() & 32'hc000_007f;
      xfer(1'b1, 8'h10, r);
      m = m | r;
      rd(8'h10, {1'b0, m});
    end
    conclude();
  end
  // the run needs a few hundred cycles
  initial begin
    repeat (3000) @(posedge core_clk);
    fails++;
    conclude();
  end
endmodule
`default_nettype wire
